// ===== verilog/dcx_ctrl.v
// Our own choices: the placing of the registers and register access over AHB-Lite.
`include "dcx_defines.vh"
module dcx_ctrl #(
	parameter TO_CYC = `DCX_DMA_TIMEOUT_CYC,
	parameter TO_W = 20
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg hresp,
	output reg [31:0] hrdata,
	input wire [1:0] drive_ready,
	input wire [1:0] write_protect,
	input wire [1:0] two_sided,
	input wire [1:0] drive_type,
	input wire [1:0] track0,
	input wire [5:0] sectors_per_track,
	input wire flaw_map_valid,
	output reg cmd_start,
	output reg [3:0] cmd_func,
	output reg cmd_unit,
	input wire eng_done,
	input wire [6:0] eng_fault,
	input wire [5:0] eng_int_code,
	input wire eng_retry,
	input wire [5:0] eng_retry_code,
	input wire dma_req,
	input wire dma_ack,
	output reg dma_abort,
	input wire seek_done,
	input wire seek_unit,
	input wire seek_mismatch,
	output reg compat_mode
);
	localparam S_IDLE = 1'b0;
	localparam S_RUN = 1'b1;

	reg state;
	reg [3:0] func;
	reg done;
	reg err;
	reg seek_av;
	reg seeks_fin;
	reg [1:0] seek_busy;
	reg [15:0] status_word;
	reg [15:0] param_word;
	reg [4:0] unit_word;
	reg retry_seen;
	reg deleted_seen;
	reg [1:0] media_clr;
	reg [TO_W-1:0] to_cnt;
	reg wr_pend;
	reg [7:0] wr_addr;
	wire [1:0] media_chg;
	wire sel_ok;
	wire wr_csr;
	wire go_req;
	wire [3:0] go_func;
	wire unit;
	wire rw_cmd;
	wire [6:0] flt_eff;
	wire [5:0] run_code;

	//////////////////////////////////////////////////////////////////////
	// helpers

	function [15:0] mk_status;
		input [5:0] code;
		input u;
		input sc;
		input rf;
		input dd;
		begin
			mk_status = 16'h0000;
			mk_status[`DCX_SW_SC] = sc;
			mk_status[`DCX_SW_TRK0] = track0[u];
			mk_status[`DCX_SW_EC_HI:`DCX_SW_EC_LO] = code;
			mk_status[7] = two_sided[u] & ~drive_type[u];
			mk_status[6] = write_protect[u];
			mk_status[5] = rf;
			mk_status[4] = drive_ready[u];
			mk_status[3] = dd;
			mk_status[2] = media_chg[u];
			mk_status[1] = drive_type[u];
			mk_status[0] = u;
		end
	endfunction

	function [5:0] err_pick;
		input [6:0] f;
		input [5:0] icode;
		begin
			if (f[`DCX_FLT_INTERNAL])
				err_pick = (icode >= `DCX_EC_INT_LO) ? icode
					: `DCX_EC_INT_LO;
			else if (f[`DCX_FLT_DMA])
				err_pick = `DCX_EC_DMA;
			else if (f[`DCX_FLT_LATE])
				err_pick = `DCX_EC_LATE;
			else if (f[`DCX_FLT_FLAWED])
				err_pick = `DCX_EC_FLAWED;
			else if (f[`DCX_FLT_DELETED])
				err_pick = `DCX_EC_DELETED;
			else if (f[`DCX_FLT_SEEK])
				err_pick = `DCX_EC_SEEK;
			else if (f[`DCX_FLT_CRC])
				err_pick = `DCX_EC_CRC;
			else
				err_pick = `DCX_EC_NONE;
		end
	endfunction

	//////////////////////////////////////////////////////////////////////
	// bus decode

	assign sel_ok = hsel & htrans[1] & hready;
	assign wr_csr = wr_pend && (wr_addr == `DCX_OFS_CSR);
	assign go_func = hwdata[`DCX_CSR_FUNC_HI:`DCX_CSR_FUNC_LO];
	assign go_req = wr_csr && hwdata[`DCX_CSR_GO] && (state == S_IDLE);
	assign unit = unit_word[`DCX_UW_UNIT];
	assign rw_cmd = (go_func == `DCX_F_WRITE) || (go_func == `DCX_F_READ)
		|| (go_func == `DCX_F_WRDEL);
	// skip select masks the deleted-mark error; fixed drives never raise it, status bit 3 still shows the mark
	// logical addressing skips flawed sectors silently
	assign flt_eff = {eng_fault[6:4],
		eng_fault[`DCX_FLT_DELETED] & ~unit_word[`DCX_UW_DSKIP]
			& ~drive_type[cmd_unit],
		eng_fault[`DCX_FLT_FLAWED] & unit_word[`DCX_UW_PHYS],
		eng_fault[1:0]};
	assign run_code = err_pick(flt_eff, eng_int_code);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b0;
			hresp <= 1'b0;
			hrdata <= 32'h00000000;
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			unit_word <= 5'h00;
			param_word <= 16'h0000;
		end else begin
			// zero wait states, always okay
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend <= sel_ok & hwrite;
			if (sel_ok)
				wr_addr <= haddr[7:0];
			if (sel_ok && !hwrite) begin
				case (haddr[7:0])
				`DCX_OFS_CSR: hrdata <= {21'h000000, state, compat_mode,
					seeks_fin, seek_av, err, done, func, 1'b0};
				`DCX_OFS_DATA: hrdata <= {16'h0000, status_word};
				`DCX_OFS_UNIT: hrdata <= {27'h0000000, unit_word};
				default: hrdata <= 32'h00000000;
				endcase
			end
			if (wr_pend && wr_addr == `DCX_OFS_UNIT)
				unit_word <= hwdata[4:0];
			if (wr_pend && wr_addr == `DCX_OFS_DATA)
				param_word <= hwdata[15:0];
		end
	end

	//////////////////////////////////////////////////////////////////////
	// media change flags

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_media
			dcx_media_watch u_watch (
				.hclk(hclk),
				.hresetn(hresetn),
				.ready(drive_ready[gi]),
				.clear(media_clr[gi]),
				.flag(media_chg[gi])
			);
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////
	// command sequencer

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= S_IDLE;
			func <= 4'h0;
			done <= 1'b1;
			err <= 1'b0;
			seek_av <= 1'b0;
			seeks_fin <= 1'b1;
			seek_busy <= 2'b00;
			status_word <= 16'h0000;
			retry_seen <= 1'b0;
			deleted_seen <= 1'b0;
			media_clr <= 2'b00;
			to_cnt <= {TO_W{1'b0}};
			cmd_start <= 1'b0;
			cmd_func <= 4'h0;
			cmd_unit <= 1'b0;
			dma_abort <= 1'b0;
			compat_mode <= 1'b0;
		end else begin
			cmd_start <= 1'b0;
			dma_abort <= 1'b0;
			media_clr <= 2'b00;
			// seek completion runs beside any primary command
			if (seek_done) begin
				seek_busy[seek_unit] <= 1'b0;
				if ((seek_busy & ~(2'b01 << seek_unit)) == 2'b00) begin
					seeks_fin <= 1'b1;
					seek_av <= 1'b0;
				end
				if (state == S_IDLE && !go_req) begin
					done <= 1'b1;
					err <= seek_mismatch;
					status_word <= mk_status(seek_mismatch ? `DCX_EC_SEEK
						: `DCX_EC_NONE, seek_unit, 1'b1, 1'b0, 1'b0);
					media_clr[seek_unit] <= 1'b1;
				end
			end
			case (state)
			S_IDLE: begin
				if (go_req) begin
					func <= go_func;
					done <= 1'b0;
					err <= 1'b0;
					retry_seen <= 1'b0;
					deleted_seen <= 1'b0;
					if (go_func > `DCX_F_LAST) begin
						err <= 1'b1;
						done <= 1'b1;
						status_word <= mk_status(`DCX_EC_ILLEGAL, unit,
							1'b0, 1'b0, 1'b0);
					end else if (go_func == `DCX_F_SETMODE) begin
						done <= 1'b1;
						if (!seeks_fin) begin
							err <= 1'b1;
							status_word <= mk_status(`DCX_EC_ILLEGAL, unit,
								1'b0, 1'b0, 1'b0);
						end else if (param_word != `DCX_MODE_KEY) begin
							err <= 1'b1;
							status_word <= mk_status(`DCX_EC_KEYWORD, unit,
								1'b0, 1'b0, 1'b0);
						end else begin
							compat_mode <= 1'b1;
							status_word <= mk_status(`DCX_EC_NONE, unit,
								1'b0, 1'b0, 1'b0);
						end
					end else if (seek_busy[unit]) begin
						err <= 1'b1;
						done <= 1'b1;
						status_word <= mk_status(`DCX_EC_INUSE, unit,
							1'b0, 1'b0, 1'b0);
					end else if (go_func == `DCX_F_RDSTAT) begin
						// never sets error
						done <= 1'b1;
						status_word <= mk_status(`DCX_EC_NONE, unit,
							1'b0, 1'b0, 1'b0);
						media_clr[unit] <= 1'b1;
					end else if (rw_cmd && unit_word[`DCX_UW_ILEAVE]
						&& sectors_per_track != `DCX_LEGACY_SPT) begin
						err <= 1'b1;
						done <= 1'b1;
						status_word <= mk_status(`DCX_EC_LEGACY, unit,
							1'b0, 1'b0, 1'b0);
					end else if (rw_cmd && unit_word[`DCX_UW_FLAWMAP]
						&& !flaw_map_valid) begin
						err <= 1'b1;
						done <= 1'b1;
						status_word <= mk_status(`DCX_EC_FLAWMAP, unit,
							1'b0, 1'b0, 1'b0);
					end else if (go_func == `DCX_F_SEEK) begin
						seek_busy[unit] <= 1'b1;
						seek_av <= 1'b1;
						seeks_fin <= 1'b0;
						cmd_start <= 1'b1;
						cmd_func <= go_func;
						cmd_unit <= unit;
					end else begin
						cmd_start <= 1'b1;
						cmd_func <= go_func;
						cmd_unit <= unit;
						to_cnt <= {TO_W{1'b0}};
						state <= S_RUN;
					end
				end
			end
			S_RUN: begin
				if (dma_req && !dma_ack)
					to_cnt <= to_cnt + {{(TO_W-1){1'b0}}, 1'b1};
				else
					to_cnt <= {TO_W{1'b0}};
				if (dma_req && !dma_ack && to_cnt == TO_CYC - 1) begin
					// abandon the access, the engine must drop its request
					dma_abort <= 1'b1;
					done <= 1'b1;
					err <= 1'b1;
					status_word <= mk_status(`DCX_EC_TIMEOUT, cmd_unit,
						1'b0, retry_seen, deleted_seen);
					media_clr[cmd_unit] <= 1'b1;
					state <= S_IDLE;
				end else if (eng_done) begin
					done <= 1'b1;
					state <= S_IDLE;
					media_clr[cmd_unit] <= 1'b1;
					retry_seen <= eng_retry;
					deleted_seen <= eng_fault[`DCX_FLT_DELETED];
					if (run_code != `DCX_EC_NONE) begin
						err <= 1'b1;
						status_word <= mk_status(run_code, cmd_unit, 1'b0,
							eng_retry, eng_fault[`DCX_FLT_DELETED]);
					end else begin
						err <= 1'b0;
						status_word <= mk_status(eng_retry ? eng_retry_code
							: `DCX_EC_NONE, cmd_unit, 1'b0, eng_retry,
							eng_fault[`DCX_FLT_DELETED]);
					end
				end
			end
			default: state <= S_IDLE;
			endcase
		end
	end
endmodule // dcx_ctrl

// ===== verilog/dcx_defines.vh
`ifndef DCX_DEFINES_VH
`define DCX_DEFINES_VH
// register byte offsets
`define DCX_OFS_CSR 8'h00
`define DCX_OFS_DATA 8'h04
`define DCX_OFS_UNIT 8'h08
// command_status_reg fields
`define DCX_CSR_GO 0
`define DCX_CSR_FUNC_LO 1
`define DCX_CSR_FUNC_HI 4
`define DCX_CSR_DONE 5
`define DCX_CSR_ERR 6
`define DCX_CSR_AVAIL 7
`define DCX_CSR_SEEKS_FIN 8
`define DCX_CSR_COMPAT 9
`define DCX_CSR_BUSY 10
// unit word fields
`define DCX_UW_UNIT 0
`define DCX_UW_DSKIP 1
`define DCX_UW_ILEAVE 2
`define DCX_UW_FLAWMAP 3
`define DCX_UW_PHYS 4
// completion status word fields
`define DCX_SW_SC 15
`define DCX_SW_TRK0 14
`define DCX_SW_EC_LO 8
`define DCX_SW_EC_HI 13
// function codes
`define DCX_F_SEEK 4'h0
`define DCX_F_WRITE 4'h2
`define DCX_F_READ 4'h3
`define DCX_F_SETMODE 4'h4
`define DCX_F_RDSTAT 4'h5
`define DCX_F_WRDEL 4'h6
`define DCX_F_LAST 4'hd
// engine fault vector bits
`define DCX_FLT_DMA 0
`define DCX_FLT_LATE 1
`define DCX_FLT_FLAWED 2
`define DCX_FLT_DELETED 3
`define DCX_FLT_SEEK 4
`define DCX_FLT_CRC 5
`define DCX_FLT_INTERNAL 6
// error codes
`define DCX_EC_NONE 6'h00
`define DCX_EC_DELETED 6'h0b
`define DCX_EC_KEYWORD 6'h0c
`define DCX_EC_DMA 6'h0d
`define DCX_EC_SEEK 6'h0f
`define DCX_EC_CRC 6'h12
`define DCX_EC_LATE 6'h14
`define DCX_EC_TIMEOUT 6'h15
`define DCX_EC_INUSE 6'h19
`define DCX_EC_LEGACY 6'h1a
`define DCX_EC_FLAWMAP 6'h1b
`define DCX_EC_ILLEGAL 6'h1c
`define DCX_EC_FLAWED 6'h21
`define DCX_EC_INT_LO 6'h30
// mode key and geometry
`define DCX_MODE_KEY 16'h4543
`define DCX_LEGACY_SPT 6'h1a
// timing
`define DCX_CLK_KHZ 40000
`define DCX_DMA_TIMEOUT_MS 20
`define DCX_DMA_TIMEOUT_CYC (`DCX_DMA_TIMEOUT_MS * `DCX_CLK_KHZ)
`endif

// ===== verilog/dcx_media_watch.v
module dcx_media_watch (
	input wire hclk,
	input wire hresetn,
	input wire ready,
	input wire clear,
	output reg flag
);
	reg ready_q;

	//////////////////////////////////////////////////////////////////////
	// ready rise detect
	// a rising ready covers both ready-lost-ready and plain not-ready-ready
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ready_q <= 1'b0;
			flag <= 1'b0;
		end else begin
			ready_q <= ready;
			// set beats a clear in the same cycle
			if (ready && !ready_q)
				flag <= 1'b1;
			else if (clear)
				flag <= 1'b0;
		end
	end
endmodule // dcx_media_watch

// ===== bench/dcx_checker.sv
module dcx_chk #(
	parameter TO_CYC = 16
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire hreadyout,
	input wire hresp,
	input wire [31:0] hrdata,
	input wire cmd_start,
	input wire [3:0] cmd_func,
	input wire dma_req,
	input wire dma_ack,
	input wire dma_abort
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	////////////////////////////////////////////////////////////////////////
	// cycles of an unanswered memory request
	reg [31:0] pend;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pend <= 32'h0;
		else if (dma_req && !dma_ack)
			pend <= pend + 32'h1;
		else
			pend <= 32'h0;
	end
	////////////////////////////////////////////////////////////////////////
	resp_okay_a: assert property (hresp == 1'b0)
		else $error("slave gave an error response");
	ready_up_a: assert property ($past(hresetn) |-> hreadyout)
		else $error("wait state inserted");
	rdata_hold_a: assert property (
		!$past(hsel && htrans[1] && hready && !hwrite) |-> $stable(hrdata))
		else $error("read data moved without a read");
	start_pulse_a: assert property (cmd_start |=> !cmd_start)
		else $error("start longer than one cycle");
	start_func_a: assert property (cmd_start |->
		cmd_func <= 4'hd && cmd_func != 4'h4 && cmd_func != 4'h5)
		else $error("engine started for an immediate function");
	func_hold_a: assert property (!cmd_start |-> $stable(cmd_func))
		else $error("function changed without a start");
	abort_cause_a: assert property (
		dma_abort |-> $past(dma_req && !dma_ack))
		else $error("abort without a pending request");
	abort_pulse_a: assert property (dma_abort |=> !dma_abort)
		else $error("abort longer than one cycle");
	// slack covers the bench dropping the request after the abort
	wait_bound_a: assert property (pend <= TO_CYC + 4)
		else $error("memory request never abandoned");
endmodule // dcx_chk

// ===== bench/test_disk_ctrl_ext_cmd_status.sv
`include "dcx_defines.vh"
module test_disk_ctrl_ext_cmd_status;
	timeunit 1ns;
	timeprecision 100ps;
	reg hclk = 1'b0;
	reg hresetn = 1'b0;
	reg hsel = 1'b0;
	reg [31:0] haddr = 32'h0;
	reg [1:0] htrans = 2'h0;
	reg hwrite = 1'b0;
	reg [31:0] hwdata = 32'h0;
	reg [1:0] drive_ready = 2'h0;
	reg [1:0] write_protect = 2'h0;
	reg [1:0] two_sided = 2'h0;
	reg [1:0] drive_type = 2'h0;
	reg flaw_map_valid = 1'b0;
	reg [5:0] sectors_per_track = 6'h10;
	reg eng_done = 1'b0;
	reg [6:0] eng_fault = 7'h0;
	reg [5:0] eng_int_code = 6'h31;
	reg eng_retry = 1'b0;
	reg [5:0] eng_retry_code = 6'h0;
	reg dma_req = 1'b0;
	reg dma_ack = 1'b0;
	reg seek_done = 1'b0;
	reg seek_unit = 1'b0;
	reg seek_mismatch = 1'b0;
	wire hreadyout, hresp, cmd_start, cmd_unit, dma_abort, compat_mode;
	wire [31:0] hrdata;
	wire [3:0] cmd_func;
	integer mismatches = 0;
	integer checked = 0;
	reg [31:0] rd;
	always #12.5 hclk = ~hclk;
	dcx_ctrl #(.TO_CYC(16)) dcx_ctrl_inst (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .drive_ready(drive_ready),
		.write_protect(write_protect), .two_sided(two_sided),
		.drive_type(drive_type), .track0(2'h0),
		.sectors_per_track(sectors_per_track),
		.flaw_map_valid(flaw_map_valid), .cmd_start(cmd_start),
		.cmd_func(cmd_func),
		.cmd_unit(cmd_unit), .eng_done(eng_done), .eng_fault(eng_fault),
		.eng_int_code(eng_int_code), .eng_retry(eng_retry),
		.eng_retry_code(eng_retry_code), .dma_req(dma_req),
		.dma_ack(dma_ack), .dma_abort(dma_abort), .seek_done(seek_done),
		.seek_unit(seek_unit), .seek_mismatch(seek_mismatch),
		.compat_mode(compat_mode));
	////////////////////////////////////////////////////////////////////////
	task final_report;
		begin
			$display("counts: %0d checked, %0d mismatches",
				checked, mismatches);
			if (mismatches == 0 && checked > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				mismatches = mismatches + 1;
				$display("unexpected at %0t: seen %h expected %h",
					$time, seen, exp);
			end
		end
	endtask
	task lim(input integer i, input integer n);
		if (i >= n) begin
			mismatches = mismatches + 1;
			final_report;
		end
	endtask
	// hready is sampled at every edge; no fixed latency assumed
	task rdy;
		integer i;
		begin
			i = 0;
			@(posedge hclk);
			while (hreadyout !== 1'b1 && i < 50) begin
				i = i + 1;
				@(posedge hclk);
			end
			lim(i, 50);
		end
	endtask
	task xfer(input w, input [7:0] a, input [31:0] d);
		begin
			hsel <= 1'b1;
			htrans <= 2'h2;
			hwrite <= w;
			haddr <= {24'h0, a};
			rdy;
			htrans <= 2'h0;
			hwdata <= d;
			rdy;
			rd = hrdata;
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task rdr(input [7:0] a);
		xfer(1'b0, a, 32'h0);
	endtask
	task go(input [3:0] f);
		wr(`DCX_OFS_CSR, {27'h0, f, 1'b1});
	endtask
	task code(input [5:0] c, input e);
		integer i;
		begin
			i = 0;
			rdr(`DCX_OFS_CSR);
			while (rd[5] !== 1'b1 && i < 40) begin
				i = i + 1;
				rdr(`DCX_OFS_CSR);
			end
			lim(i, 40);
			chk(rd[6], e);
			rdr(`DCX_OFS_DATA);
			chk(rd[13:8], c);
		end
	endtask
	task eng(input [6:0] f, input r, input [5:0] rc);
		begin
			eng_done <= 1'b1;
			eng_fault <= f;
			eng_retry <= r;
			eng_retry_code <= rc;
			@(posedge hclk);
			eng_done <= 1'b0;
			@(posedge hclk);
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	task t_regs;
		begin
			rdr(`DCX_OFS_CSR);
			chk(rd, 32'h120);
			rdr(8'h0c);
			chk(rd, 32'h0);
			$display("test regs done");
		end
	endtask
	task t_status;
		begin
			drive_ready <= 2'h1;
			write_protect <= 2'h1;
			two_sided <= 2'h1;
			@(posedge hclk);
			wr(`DCX_OFS_UNIT, 32'h0);
			go(`DCX_F_RDSTAT);
			code(6'h0, 1'b0);
			chk(rd[7:2], 6'h35);
			go(`DCX_F_RDSTAT);
			code(6'h0, 1'b0);
			chk(rd[7:2], 6'h34);
			drive_type <= 2'h1;
			go(`DCX_F_RDSTAT);
			code(6'h0, 1'b0);
			chk(rd[7:0], 8'h52);
			drive_type <= 2'h0;
			$display("test status done");
		end
	endtask
	task t_illegal;
		integer f;
		begin
			for (f = 14; f < 16; f = f + 1) begin
				go(f[3:0]);
				code(6'h1c, 1'b1);
			end
			$display("test illegal done");
		end
	endtask
	function [12:0] row(input [2:0] i);
		case (i)
			3'h0: row = {7'h21, 6'h0d};
			3'h1: row = {7'h20, 6'h12};
			3'h2: row = {7'h22, 6'h14};
			3'h3: row = {7'h24, 6'h21};
			3'h4: row = {7'h28, 6'h0b};
			3'h5: row = {7'h30, 6'h0f};
			default: row = {7'h41, 6'h31};
		endcase
	endfunction
	task t_faults;
		integer i;
		reg [12:0] r;
		begin
			for (i = 0; i < 7; i = i + 1) begin
				r = row(i[2:0]);
				// physical addressing, so a flawed sector is reported
				wr(`DCX_OFS_UNIT, 32'h10);
				go(`DCX_F_READ);
				rdr(`DCX_OFS_CSR);
				chk(rd[5], 1'b0);
				eng(r[12:6], 1'b0, 6'h0);
				code(r[5:0], 1'b1);
			end
			wr(`DCX_OFS_UNIT, 32'h0);
			go(`DCX_F_READ);
			eng(7'h04, 1'b0, 6'h0);
			code(6'h0, 1'b0);
			go(`DCX_F_READ);
			eng(7'h0, 1'b1, 6'h12);
			code(6'h12, 1'b0);
			chk(rd[5], 1'b1);
			wr(`DCX_OFS_UNIT, 32'h3);
			go(`DCX_F_READ);
			eng(7'h08, 1'b0, 6'h0);
			code(6'h0, 1'b0);
			chk(rd[3], 1'b1);
			chk(cmd_unit, 1'b1);
			drive_type <= 2'h2;
			wr(`DCX_OFS_UNIT, 32'h1);
			go(`DCX_F_READ);
			eng(7'h08, 1'b0, 6'h0);
			code(6'h0, 1'b0);
			drive_type <= 2'h0;
			$display("test faults done");
		end
	endtask
	task t_timeout;
		integer i;
		begin
			wr(`DCX_OFS_UNIT, 32'h0);
			go(`DCX_F_READ);
			dma_req <= 1'b1;
			i = 0;
			@(negedge hclk);
			while (dma_abort !== 1'b1 && i < 100) begin
				i = i + 1;
				@(negedge hclk);
			end
			@(posedge hclk);
			dma_req <= 1'b0;
			lim(i, 100);
			chk(i, 16);
			code(6'h15, 1'b1);
			$display("test timeout done");
		end
	endtask
	task t_seek;
		begin
			go(`DCX_F_SEEK);
			rdr(`DCX_OFS_CSR);
			chk({rd[8:7], rd[5]}, 3'b010);
			go(`DCX_F_SETMODE);
			code(6'h1c, 1'b1);
			chk(compat_mode, 1'b0);
			go(`DCX_F_READ);
			code(6'h19, 1'b1);
			seek_mismatch <= 1'b1;
			seek_done <= 1'b1;
			@(posedge hclk);
			seek_done <= 1'b0;
			code(6'h0f, 1'b1);
			chk(rd[15], 1'b1);
			$display("test seek done");
		end
	endtask
	// host initialises after the seek error
	task t_init;
		begin
			hresetn <= 1'b0;
			repeat (3) @(posedge hclk);
			hresetn <= 1'b1;
			repeat (2) @(posedge hclk);
			rdr(`DCX_OFS_CSR);
			chk(rd, 32'h120);
			$display("test init done");
		end
	endtask
	task t_mode;
		begin
			wr(`DCX_OFS_UNIT, 32'h4);
			go(`DCX_F_READ);
			code(6'h1a, 1'b1);
			sectors_per_track <= 6'h1a;
			go(`DCX_F_READ);
			eng(7'h0, 1'b0, 6'h0);
			code(6'h0, 1'b0);
			wr(`DCX_OFS_UNIT, 32'h8);
			go(`DCX_F_READ);
			code(6'h1b, 1'b1);
			flaw_map_valid <= 1'b1;
			go(`DCX_F_READ);
			eng(7'h0, 1'b0, 6'h0);
			code(6'h0, 1'b0);
			wr(`DCX_OFS_DATA, 32'h0);
			go(`DCX_F_SETMODE);
			code(6'h0c, 1'b1);
			chk(compat_mode, 1'b0);
			wr(`DCX_OFS_DATA, {16'h0, `DCX_MODE_KEY});
			go(`DCX_F_SETMODE);
			code(6'h0, 1'b0);
			chk(compat_mode, 1'b1);
			$display("test mode done");
		end
	endtask
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		t_regs;
		t_status;
		t_illegal;
		t_faults;
		t_timeout;
		t_seek;
		t_init;
		t_mode;
		final_report;
	end
endmodule // test_disk_ctrl_ext_cmd_status
bind dcx_ctrl dcx_chk #(.TO_CYC(TO_CYC)) dcx_chk_inst (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .cmd_start(cmd_start),
	.cmd_func(cmd_func), .dma_req(dma_req), .dma_ack(dma_ack),
	.dma_abort(dma_abort));
